// *** rtl/urx_cfg.svh ***
// Purpose: offsets, field positions, reset values and counts for urx
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   included by its bare name
// What this block does
// - three samples per bit, majority vote
// - sample disagreement sets noise flag, error irq
// - single-sample mode never reports noise
// - finished frame sets rx_full_flag, irq, status
// - data read or dma ack clears rx_full_flag
// - parity mismatch sets parity_fail_flag, irq
// - low stop bit sets framing_fail_flag, irq
// - stop length selects which stop bit is sampled
// - second stop checked only if first good
// - frame while full discarded, overrun flag, irq
// - frame end updates full or overrun, noise, parity and framing flags in one cycle
// - dma requests per enable; tx_done_flag after frame
// - error irq covers framing, overrun, noise
// - rx_hold_out high while receive buffer full
// - start tx only with permit low
// - drive output with lead, lag and polarity
// - mute_request mutes; muted sets no flags unless a matching frame wakes it
// - idle frame: flag, or wake when muted
// - address frame match wakes, mismatch mutes
// - data match wakes and receives, mismatch mutes
// - parity on: top bit parity, narrower wide compare for 8-bit words
`ifndef URX_CFG_SVH
`define URX_CFG_SVH

`define URX_OFS_CTRL      8'h00
`define URX_OFS_TIMING    8'h04
`define URX_OFS_STATUS    8'h08
`define URX_OFS_FLAGCLR   8'h0C
`define URX_OFS_CMD       8'h10
`define URX_OFS_RDATA     8'h14

`define URX_CTRL_RESET    32'h0000_0000
`define URX_TIMING_RESET  32'h0000_0000

`define URX_TIM_LEAD_LSB  0
`define URX_TIM_LAG_LSB   8
`define URX_TIM_MATCH_LSB 16
`define URX_CMD_MUTE_BIT  0

`define URX_OS_WIDE       5'h10
`define URX_OS_NARROW     5'h08
`define URX_MID_WIDE      5'h08
`define URX_MID_NARROW    5'h04

`define URX_STOP_ONE      2'b00
`define URX_STOP_HALF     2'b01
`define URX_STOP_TWO      2'b10
`define URX_STOP_ONEHALF  2'b11

`define URX_WAKE_IDLE     2'b00
`define URX_WAKE_ADDR     2'b01

`endif

// *** rtl/urx_pkg.sv ***
// Purpose: types shared by the urx receiver
// Assumes: constants come from urx_cfg.svh
// Notes:   control and status words map onto register bits lsb first
package urx_pkg;

    typedef enum logic [4:0] {
        URX_R_IDLE  = 5'b00001,
        URX_R_START = 5'b00010,
        URX_R_DATA  = 5'b00100,
        URX_R_HALF  = 5'b01000,
        URX_R_STOP  = 5'b10000
    } urx_rx_state_t;

    typedef enum logic [3:0] {
        URX_T_IDLE = 4'b0001,
        URX_T_LEAD = 4'b0010,
        URX_T_BUSY = 4'b0100,
        URX_T_LAG  = 4'b1000
    } urx_tx_state_t;

    typedef struct packed {
        logic [8:0] spare;
        logic       tx_done_irq_en;
        logic       error_irq_en;
        logic       parity_fail_irq_en;
        logic       rx_full_irq_en;
        logic       drive_polarity_sel;
        logic       transceiver_drive_ctl_en;
        logic       cts_flow_en;
        logic       rts_flow_en;
        logic       tx_dma_en;
        logic       rx_dma_en;
        logic       mute_feature_on;
        logic       match_width_sel;
        logic [1:0] wake_method;
        logic [1:0] stop_len_sel;
        logic       single_sample_sel;
        logic       over8_sel;
        logic       parity_odd_sel;
        logic       parity_check_on;
        logic       word_len_sel;
        logic       rx_en;
        logic       unit_enable;
    } urx_ctrl_t;

    typedef struct packed {
        logic tx_done_flag;
        logic idle_line_flag;
        logic overrun_flag;
        logic framing_fail_flag;
        logic parity_fail_flag;
        logic noise_flag;
        logic rx_full_flag;
    } urx_flags_t;

endpackage

// *** rtl/urx_top.sv ***
// Purpose: serial receive path with flow control, drive enable and mute
// Assumes: sample_tick_i pulses once per oversampling period
// Notes:   transmitter core sits outside; this block gates its starts
`timescale 1ns/10ps
`include "urx_cfg.svh"

module urx_top (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        sample_tick_i,
    input  wire logic        rx_pin_i,
    input  wire logic        tx_permit_in_i,
    input  wire logic        tx_pending_i,
    input  wire logic        tx_empty_i,
    input  wire logic        tx_frame_end_i,
    output logic             tx_go_o,
    input  wire logic        rx_dma_ack_i,
    output logic             rx_dma_req_o,
    output logic             tx_dma_req_o,
    output logic             rx_hold_out_o,
    output logic             transceiver_drive_out_o,
    output logic             irq_o
);

    urx_pkg::urx_ctrl_t     ctrl_r;
    logic [31:0]            timing_r;
    urx_pkg::urx_flags_t    flags_r;
    logic [8:0]             rdata_buf_r;
    logic [31:0]            rdata_r;
    logic                   rx_mute_state_r;
    logic                   rx_s1_r, rx_s2_r, rx_prev_r;
    logic                   pm_s1_r, pm_s2_r;
    urx_pkg::urx_rx_state_t rst_r;
    logic [4:0]             cnt_r;
    logic [4:0]             cnt_nxt;
    logic [3:0]             bitn_r;
    logic [2:0]             smp_r;
    logic                   dec_r;
    logic                   second_r;
    logic                   noise_acc_r;
    logic                   framing_fail_flag_acc_r;
    logic [8:0]             sh_r;
    logic [7:0]             icnt_r;
    logic                   idle_arm_r;
    urx_pkg::urx_tx_state_t tst_r;
    logic [4:0]             tcnt_r;
    logic                   go_r;
    logic                   hold_r;
    logic                   drive_r;
    logic                   irq_r;

    logic [4:0] os, mid, half;
    logic       rx_on, bit_val, bit_noise, bit_end;
    logic       done, fr_framing_fail_flag, fr_noise, fr_parity_fail_flag, keep, idle_ev;
    logic [8:0] fw;
    logic       aflag, match;
    logic [7:0] match_val, mask;
    logic       wr_ctrl, wr_tim, wr_clr, wr_cmd, rd_data;
    logic       tx_ok;
    logic [4:0] lead, lag;

    // majority of three samples
    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction

    // bits of the frame word that take part in a match
    function automatic logic [7:0] cmp_mask(input logic wide,
                                            input logic par,
                                            input logic w9,
                                            input logic dmatch);
        if (!wide)
            cmp_mask = 8'h0F;
        else if (par)
            cmp_mask = w9 ? 8'hFF : 8'h3F;
        else
            cmp_mask = dmatch ? 8'hFF : 8'h7F;
    endfunction

    // position of the address flag, just below any parity bit
    function automatic logic [3:0] aflag_pos(input logic par,
                                             input logic w9);
        aflag_pos = {3'b011, 1'b0} + {3'b000, w9} - {3'b000, par} + 4'h1;
    endfunction

    // register port decode
    assign wr_ctrl = wr_i && (addr_i == `URX_OFS_CTRL);
    assign wr_tim  = wr_i && (addr_i == `URX_OFS_TIMING);
    assign wr_clr  = wr_i && (addr_i == `URX_OFS_FLAGCLR);
    assign wr_cmd  = wr_i && (addr_i == `URX_OFS_CMD);
    assign rd_data = rd_i && (addr_i == `URX_OFS_RDATA);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ctrl_r   <= urx_pkg::urx_ctrl_t'(`URX_CTRL_RESET);
            timing_r <= `URX_TIMING_RESET;
        end else begin
            if (wr_ctrl)
                ctrl_r <= urx_pkg::urx_ctrl_t'(wdata_i);
            if (wr_tim)
                timing_r <= wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                `URX_OFS_CTRL:   rdata_r <= ctrl_r;
                `URX_OFS_TIMING: rdata_r <= timing_r;
                `URX_OFS_STATUS: rdata_r <= {22'h00_0000,
                    rst_r != urx_pkg::URX_R_IDLE, tx_empty_i,
                    rx_mute_state_r, flags_r};
                `URX_OFS_RDATA:  rdata_r <= {23'h00_0000, rdata_buf_r};
                default:         rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end
    assign rdata_o = rdata_r;

    // pin synchronisers
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rx_s1_r   <= 1'b1;
            rx_s2_r   <= 1'b1;
            rx_prev_r <= 1'b1;
            pm_s1_r   <= 1'b1;
            pm_s2_r   <= 1'b1;
        end else begin
            rx_s1_r   <= rx_pin_i;
            rx_s2_r   <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
            pm_s1_r   <= tx_permit_in_i;
            pm_s2_r   <= pm_s1_r;
        end
    end

    // bit timing and sample selection
    assign rx_on   = ctrl_r.unit_enable && ctrl_r.rx_en;
    assign os      = ctrl_r.over8_sel ? `URX_OS_NARROW : `URX_OS_WIDE;
    assign mid     = ctrl_r.over8_sel ? `URX_MID_NARROW : `URX_MID_WIDE;
    assign half    = {1'b0, os[4:1]};
    assign cnt_nxt = cnt_r + 5'h01;
    assign bit_end = sample_tick_i && (cnt_nxt == os);
    // one sample in single mode, else majority of three
    assign bit_val = ctrl_r.single_sample_sel ? smp_r[1] : maj3(smp_r);
    assign bit_noise = !ctrl_r.single_sample_sel &&
                       !(&smp_r || ~|smp_r);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            smp_r <= 3'b111;
            dec_r <= 1'b0;
        end else begin
            dec_r <= 1'b0;
            if (sample_tick_i && rst_r != urx_pkg::URX_R_IDLE &&
                rst_r != urx_pkg::URX_R_HALF) begin
                // samples mid-1, mid, mid+1 of the bit
                if (cnt_nxt >= mid - 5'h01 && cnt_nxt <= mid + 5'h01)
                    smp_r <= {smp_r[1:0], rx_s2_r};
                dec_r <= (cnt_nxt == mid + 5'h01);
            end
        end
    end

    // frame end: stop decision or end of a half stop
    assign done = rx_on && (
        (rst_r == urx_pkg::URX_R_STOP && dec_r &&
         (!bit_val || ctrl_r.stop_len_sel != `URX_STOP_TWO ||
          second_r)) ||
        (rst_r == urx_pkg::URX_R_HALF && sample_tick_i &&
         cnt_nxt == half &&
         ctrl_r.stop_len_sel == `URX_STOP_HALF));
    assign fr_framing_fail_flag  = framing_fail_flag_acc_r ||
        (rst_r == urx_pkg::URX_R_STOP && dec_r && !bit_val);
    assign fr_noise = noise_acc_r || (dec_r && bit_noise);
    assign fw = ctrl_r.word_len_sel ? sh_r : {1'b0, sh_r[8:1]};
    assign fr_parity_fail_flag = ctrl_r.parity_check_on &&
                     ((^fw) != ctrl_r.parity_odd_sel);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rst_r       <= urx_pkg::URX_R_IDLE;
            cnt_r       <= 5'h00;
            bitn_r      <= 4'h0;
            second_r    <= 1'b0;
            noise_acc_r <= 1'b0;
            framing_fail_flag_acc_r  <= 1'b0;
            sh_r        <= 9'h000;
        end else if (!rx_on) begin
            rst_r <= urx_pkg::URX_R_IDLE; // frame dropped
            cnt_r <= 5'h00;
        end else begin
            if (sample_tick_i)
                cnt_r <= bit_end ? 5'h00 : cnt_nxt;
            if (dec_r)
                noise_acc_r <= fr_noise;
            case (rst_r)
                urx_pkg::URX_R_IDLE: begin
                    cnt_r <= 5'h00;
                    if (rx_prev_r && !rx_s2_r) begin
                        rst_r       <= urx_pkg::URX_R_START;
                        noise_acc_r <= 1'b0;
                        framing_fail_flag_acc_r  <= 1'b0;
                        second_r    <= 1'b0;
                        bitn_r      <= 4'h0;
                    end
                end
                urx_pkg::URX_R_START: begin
                    if (dec_r && bit_val)
                        rst_r <= urx_pkg::URX_R_IDLE;
                    else if (bit_end)
                        rst_r <= urx_pkg::URX_R_DATA;
                end
                urx_pkg::URX_R_DATA: begin
                    if (dec_r)
                        sh_r <= {bit_val, sh_r[8:1]};
                    if (bit_end) begin
                        bitn_r <= bitn_r + 4'h1;
                        if (bitn_r == 4'h7 + 4'(ctrl_r.word_len_sel)) begin
                            // half stop first for 0.5 and 1.5
                            if (ctrl_r.stop_len_sel[0])
                                rst_r <= urx_pkg::URX_R_HALF;
                            else
                                rst_r <= urx_pkg::URX_R_STOP;
                        end
                    end
                end
                urx_pkg::URX_R_HALF: begin
                    if (sample_tick_i && cnt_nxt == half) begin
                        cnt_r <= 5'h00;
                        if (ctrl_r.stop_len_sel == `URX_STOP_HALF)
                            rst_r <= urx_pkg::URX_R_IDLE;
                        else
                            rst_r <= urx_pkg::URX_R_STOP;
                    end
                end
                urx_pkg::URX_R_STOP: begin
                    if (done)
                        rst_r <= urx_pkg::URX_R_IDLE;
                    else if (dec_r) begin
                        second_r   <= 1'b1; // first stop good
                        framing_fail_flag_acc_r <= fr_framing_fail_flag;
                    end
                end
                default: rst_r <= urx_pkg::URX_R_IDLE;
            endcase
        end
    end

    // idle frame: line high for a whole frame length
    assign idle_ev = rx_on && idle_arm_r && sample_tick_i &&
        rst_r == urx_pkg::URX_R_IDLE && rx_s2_r &&
        icnt_r + 8'h01 == 8'({4'h0, 3'b101, ctrl_r.word_len_sel}) * 8'(os);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            icnt_r     <= 8'h00;
            idle_arm_r <= 1'b1;
        end else if (rst_r != urx_pkg::URX_R_IDLE || !rx_s2_r) begin
            icnt_r     <= 8'h00;
            idle_arm_r <= 1'b1;
        end else if (idle_ev) begin
            icnt_r     <= 8'h00;
            idle_arm_r <= 1'b0;
        end else if (sample_tick_i && idle_arm_r) begin
            icnt_r <= icnt_r + 8'h01;
        end
    end

    // wake-up matching
    assign match_val = timing_r[`URX_TIM_MATCH_LSB +: 8];
    assign mask  = cmp_mask(ctrl_r.match_width_sel,
                            ctrl_r.parity_check_on,
                            ctrl_r.word_len_sel,
                            ctrl_r.wake_method[1]);
    assign aflag = fw[aflag_pos(ctrl_r.parity_check_on,
                                ctrl_r.word_len_sel)];
    assign match = ((fw[7:0] ^ match_val) & mask) == 8'h00;

    always_comb begin
        keep = !rx_mute_state_r; // muted frames set nothing unless a match wakes them
        if (ctrl_r.mute_feature_on) begin
            if (ctrl_r.wake_method == `URX_WAKE_ADDR && aflag)
                keep = match;
            else if (ctrl_r.wake_method[1])
                keep = match;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rx_mute_state_r <= 1'b0;
        end else if (wr_cmd && wdata_i[`URX_CMD_MUTE_BIT] &&
                     ctrl_r.mute_feature_on) begin
            rx_mute_state_r <= 1'b1;
        end else if (done && ctrl_r.mute_feature_on &&
                     (ctrl_r.wake_method[1] ||
                      (ctrl_r.wake_method == `URX_WAKE_ADDR && aflag))) begin
            rx_mute_state_r <= !match;
        end else if (idle_ev &&
                     ctrl_r.wake_method == `URX_WAKE_IDLE) begin
            rx_mute_state_r <= 1'b0;
        end
    end

    // status flags: set wins over clear
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            flags_r     <= '0;
            rdata_buf_r <= 9'h000;
        end else begin
            if (wr_clr)
                flags_r[6:1] <= flags_r[6:1] & ~wdata_i[6:1];
            if (rd_data || rx_dma_ack_i)
                flags_r.rx_full_flag <= 1'b0;
            if (done && keep) begin
                // full or overrun, noise, parity and framing flags in this one cycle
                if (flags_r.rx_full_flag) begin
                    flags_r.overrun_flag <= 1'b1;
                end else begin
                    flags_r.rx_full_flag <= 1'b1;
                    rdata_buf_r          <= fw;
                end
                if (fr_noise)
                    flags_r.noise_flag <= 1'b1;
                if (fr_parity_fail_flag)
                    flags_r.parity_fail_flag <= 1'b1;
                if (fr_framing_fail_flag)
                    flags_r.framing_fail_flag <= 1'b1;
            end
            if (idle_ev && !rx_mute_state_r)
                flags_r.idle_line_flag <= 1'b1;
            if (tx_frame_end_i && tx_empty_i)
                flags_r.tx_done_flag <= 1'b1;
        end
    end

    // interrupt request, dma requests and rx_hold_out
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            irq_r  <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            irq_r <= (flags_r.rx_full_flag && ctrl_r.rx_full_irq_en) ||
                (flags_r.parity_fail_flag && ctrl_r.parity_fail_irq_en) ||
                (flags_r.tx_done_flag && ctrl_r.tx_done_irq_en) ||
                (flags_r.overrun_flag &&
                 (ctrl_r.error_irq_en || ctrl_r.rx_full_irq_en)) ||
                ((flags_r.noise_flag || flags_r.framing_fail_flag) &&
                 ctrl_r.error_irq_en);
            hold_r <= ctrl_r.rts_flow_en && flags_r.rx_full_flag;
        end
    end
    assign irq_o         = irq_r;
    assign rx_hold_out_o = hold_r;
    assign rx_dma_req_o  = ctrl_r.rx_dma_en && flags_r.rx_full_flag;
    assign tx_dma_req_o  = ctrl_r.tx_dma_en && tx_empty_i;

    // transmit start gating with drive lead and lag
    assign tx_ok = ctrl_r.unit_enable && tx_pending_i &&
                   (!ctrl_r.cts_flow_en || !pm_s2_r);
    assign lead = ctrl_r.transceiver_drive_ctl_en ?
                  timing_r[`URX_TIM_LEAD_LSB +: 5] : 5'h00;
    assign lag  = ctrl_r.transceiver_drive_ctl_en ?
                  timing_r[`URX_TIM_LAG_LSB +: 5] : 5'h00;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            tst_r  <= urx_pkg::URX_T_IDLE;
            tcnt_r <= 5'h00;
            go_r   <= 1'b0;
        end else begin
            go_r <= 1'b0;
            case (tst_r)
                urx_pkg::URX_T_IDLE: begin
                    tcnt_r <= 5'h00;
                    if (tx_ok) begin
                        if (lead != 5'h00) begin
                            tst_r <= urx_pkg::URX_T_LEAD;
                        end else begin
                            go_r  <= 1'b1;
                            tst_r <= urx_pkg::URX_T_BUSY;
                        end
                    end
                end
                urx_pkg::URX_T_LEAD: begin
                    if (sample_tick_i)
                        tcnt_r <= tcnt_r + 5'h01;
                    if (sample_tick_i && tcnt_r + 5'h01 >= lead) begin
                        go_r  <= 1'b1;
                        tst_r <= urx_pkg::URX_T_BUSY;
                    end
                end
                urx_pkg::URX_T_BUSY: begin
                    tcnt_r <= 5'h00;
                    if (tx_frame_end_i) begin
                        // stop after the frame when permit rises
                        if (tx_ok)
                            go_r <= 1'b1;
                        else if (lag != 5'h00)
                            tst_r <= urx_pkg::URX_T_LAG;
                        else
                            tst_r <= urx_pkg::URX_T_IDLE;
                    end
                end
                urx_pkg::URX_T_LAG: begin
                    if (sample_tick_i)
                        tcnt_r <= tcnt_r + 5'h01;
                    if (tx_ok) begin
                        go_r  <= 1'b1;
                        tst_r <= urx_pkg::URX_T_BUSY;
                    end else if (sample_tick_i &&
                                 tcnt_r + 5'h01 >= lag) begin
                        tst_r <= urx_pkg::URX_T_IDLE;
                    end
                end
                default: tst_r <= urx_pkg::URX_T_IDLE;
            endcase
        end
    end
    assign tx_go_o = go_r;

    always_ff @(posedge clock_i) begin
        if (!resetn_i)
            drive_r <= 1'b0;
        else
            drive_r <= (ctrl_r.transceiver_drive_ctl_en &&
                        (tst_r != urx_pkg::URX_T_IDLE || tx_ok)) ^
                       ctrl_r.drive_polarity_sel;
    end
    assign transceiver_drive_out_o = drive_r;

endmodule

// *** testbench/urx_top_properties.sv ***
// Purpose: port checks for urx_top
// Assumes: bench keeps rts, rx dma and drive enables on together
// Notes:   bound below the module
`timescale 1ns/10ps
module urx_top_chk (
    input wire logic        clock_i,
    input wire logic        resetn_i,
    input wire logic [7:0]  addr_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        tx_pending_i,
    input wire logic        tx_empty_i,
    input wire logic        tx_go_o,
    input wire logic        rx_dma_ack_i,
    input wire logic        rx_dma_req_o,
    input wire logic        tx_dma_req_o,
    input wire logic        rx_hold_out_o,
    input wire logic        transceiver_drive_out_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    rd_clears_a: assert property (
        rd_i && addr_i == 8'h14 |=> !rx_dma_req_o) else $error("read kept req");
    ack_clears_a: assert property (
        rx_dma_ack_i |=> !rx_dma_req_o) else $error("ack kept req");
    hold_full_a: assert property (
        !$past(wr_i) |-> rx_hold_out_o == $past(rx_dma_req_o))
        else $error("hold not tracking full");
    irq_full_a: assert property (
        $rose(rx_dma_req_o) |=> irq_o) else $error("no irq on frame");
    tx_dma_a: assert property (
        tx_dma_req_o |-> tx_empty_i) else $error("tx req without empty");
    go_once_a: assert property (
        tx_go_o |=> !tx_go_o) else $error("go longer than one cycle");
    go_pend_a: assert property (
        tx_go_o |-> $past(tx_pending_i)) else $error("go without pending");
    go_drive_a: assert property (
        tx_go_o |-> transceiver_drive_out_o) else $error("go before drive");
    rdata_idle_a: assert property (
        !$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata not idle");
    cover property ($rose(rx_dma_req_o));
    cover property (tx_go_o);
    cover property ($fell(transceiver_drive_out_o));
endmodule
bind urx_top urx_top_chk i_chk (.*);

// *** testbench/urx_remote.sv ***
// Purpose: remote serial sender
// Assumes: 16 ticks per bit, one tick every other clock
// Notes:   line idles high between frames
`timescale 1ns/10ps
module urx_remote (
    input  wire logic       clock_i,
    input  wire logic       send_i,
    input  wire logic [8:0] frame_i,
    output logic            tick_o,
    output logic            line_o,
    output logic            busy_o
);
    logic [9:0] sh_r = 10'h3FF;
    logic [3:0] ph_r = 4'h0;
    logic [3:0] n_r  = 4'h0;
    initial tick_o = 1'b0;
    initial busy_o = 1'b0;
    assign line_o = sh_r[0];
    always @(posedge clock_i) begin
        tick_o <= !tick_o;
        if (send_i) begin
            sh_r <= {frame_i, 1'b0}; // lsb first, top bit is stop
            ph_r <= 4'h0;
            n_r <= 4'h0;
            busy_o <= 1'b1;
        end else if (busy_o && tick_o) begin
            ph_r <= ph_r + 4'h1;
            if (ph_r == 4'hF) begin
                sh_r <= {1'b1, sh_r[9:1]};
                n_r <= n_r + 4'h1;
                busy_o <= (n_r != 4'h9);
            end
        end
    end
endmodule

// *** testbench/urx_top_tb.sv ***
// Purpose: self-checking bench for urx_top
// Assumes: 16x sampling, 8-bit words, one stop bit
// Notes:   remote model feeds the rx pin and sample tick
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end
module urx_top_tb;
    localparam logic [31:0] CFG = 32'h002A_B003;
    logic        clock_i  = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  addr_i   = 8'h00;
    logic [31:0] wdata_i  = 32'h0;
    logic        wr_i = 1'b0, rd_i = 1'b0, send = 1'b0, ack = 1'b0;
    logic        permit = 1'b0, pend = 1'b0, fend = 1'b0;
    logic [8:0]  frame = 9'h1FF;
    logic [31:0] rdata_o, d;
    logic        tick, line, busy, go, rxq, txq, hold, drv, irq;
    int          bad_count = 0, checks = 0, gos = 0;
    always #2.5 clock_i = !clock_i;
    always @(posedge clock_i) if (go === 1'b1) gos++;
    urx_remote i_rem (.clock_i(clock_i), .send_i(send), .frame_i(frame),
        .tick_o(tick), .line_o(line), .busy_o(busy));
    urx_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sample_tick_i(tick), .rx_pin_i(line), .tx_permit_in_i(permit),
        .tx_pending_i(pend), .tx_empty_i(1'b1), .tx_frame_end_i(fend),
        .tx_go_o(go), .rx_dma_ack_i(ack), .rx_dma_req_o(rxq),
        .tx_dma_req_o(txq), .rx_hold_out_o(hold),
        .transceiver_drive_out_o(drv), .irq_o(irq));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tmo(input logic ok);
        if (ok !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic sendf(input logic [8:0] f); // rx stays enabled
        @(posedge clock_i);
        frame <= f;
        send <= 1'b1;
        @(posedge clock_i);
        send <= 1'b0;
        repeat (2) @(posedge clock_i);
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clock_i);
        tmo(busy === 1'b0);
        repeat (4) @(posedge clock_i);
    endtask
    task automatic pulse_end;
        @(posedge clock_i);
        pend <= 1'b0;
        fend <= 1'b1;
        @(posedge clock_i);
        fend <= 1'b0;
    endtask
    task automatic t_frame;
        wr(8'h00, CFG);
        sendf(9'h1A5);
        rd(8'h08);
        `CHK("status", 5'h01, d[4:0])
        `CHK("hold", 1'b1, hold)
        `CHK("irq", 1'b1, irq)
        sendf(9'h13C);
        rd(8'h08);
        `CHK("overrun", 5'h11, d[4:0])
        rd(8'h14);
        `CHK("data", 9'h0A5, d[8:0])
        `CHK("rxreq", 1'b0, rxq)
        rd(8'h20);
        `CHK("unmapped", 32'h0, d)
        $display("frame test done");
    endtask
    task automatic t_framing_fail_flag;
        wr(8'h0C, 32'h0000_007E);
        sendf(9'h0C3);
        rd(8'h08);
        `CHK("framing", 5'h09, d[4:0])
        @(posedge clock_i);
        ack <= 1'b1;
        @(posedge clock_i);
        ack <= 1'b0;
        #1 `CHK("ack", 1'b0, rxq)
        $display("framing test done");
    endtask
    task automatic t_mute;
        wr(8'h0C, 32'h0000_007E);
        wr(8'h10, 32'h0000_0001);
        sendf(9'h155);
        rd(8'h08);
        `CHK("muted", 8'h80, d[7:0])
        repeat (400) @(posedge clock_i);
        rd(8'h08);
        `CHK("woken", 8'h00, d[7:0])
        $display("mute test done");
    endtask
    task automatic t_tx;
        wr(8'h04, 32'h0000_0403);
        pend <= 1'b1;
        for (int i = 0; i < 100 && go !== 1'b1; i++) @(posedge clock_i);
        tmo(go === 1'b1);
        `CHK("lead", 1'b1, drv)
        `CHK("txreq", 1'b0, txq)
        pulse_end();
        repeat (4) @(posedge clock_i);
        `CHK("lag", 1'b1, drv)
        for (int i = 0; i < 100 && drv !== 1'b0; i++) @(posedge clock_i);
        `CHK("release", 1'b0, drv)
        permit <= 1'b1;
        wr(8'h00, CFG | 32'h0001_0000);
        gos = 0;
        pend <= 1'b1;
        repeat (40) @(posedge clock_i);
        `CHK("held", 0, gos)
        permit <= 1'b0;
        for (int i = 0; i < 100 && go !== 1'b1; i++) @(posedge clock_i);
        `CHK("permit", 1'b1, go)
        pulse_end();
        $display("tx gate test done");
    endtask
    initial begin
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_frame();
        t_framing_fail_flag();
        t_mute();
        t_tx();
        end_of_test();
    end
endmodule
